/* core/mem_read_unit.sv */
// read side of the external memory bus: word reads and block fetches
`timescale 1ns/1ns
module mem_read_unit
   import mem_read_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire logic req_block,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [LEN_W-1:0] req_len,
   input wire logic [ADDR_W-1:0] instr_addr,
   output logic req_ready,
   output logic [ADDR_W-1:0] addr_out,
   output logic txn_start_n,
   output logic block_fetch_request,
   output logic addr_strobe_n,
   output logic read_enable_n,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [PAR_W-1:0] data_parity_in,
   input wire logic data_ready_n,
   input wire logic bus_error_n,
   input wire logic parity_check_enable_n,
   input wire logic cacheable_n,
   input wire logic block_fetch_ack_n,
   output logic word_valid,
   output logic [DATA_W-1:0] word_data,
   output logic [PAR_W-1:0] word_parity,
   output logic word_parity_check,
   output logic word_cacheable,
   output logic word_to_cache,
   output logic txn_done,
   output logic bus_error_exc
);
   localparam logic [SYNC_W-1:0] SYNC_RST = {{(DATA_W + PAR_W){1'b0}}, 5'h1f};

   logic [SYNC_W-1:0] sync_bus;
   logic [DATA_W-1:0] data_s;
   logic [PAR_W-1:0] par_s;
   logic rdy_s;
   logic err_s;
   logic pen_s;
   logic cach_s;
   logic ack_s;

   pin_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in({data_in, data_parity_in, data_ready_n, bus_error_n,
               parity_check_enable_n, cacheable_n, block_fetch_ack_n}),
      .pin_sync_out(sync_bus)
   );

   assign {data_s, par_s} = sync_bus[SYNC_W-1:5];
   assign rdy_s = ~sync_bus[4];
   assign err_s = ~sync_bus[3];
   assign pen_s = ~sync_bus[2];
   assign cach_s = ~sync_bus[1];
   assign ack_s = ~sync_bus[0];

   rd_state_type state_q, state_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [LEN_W-1:0] len_q, len_d;
   logic [LEN_W-1:0] count_q, count_d;
   logic block_q, block_d;
   logic burst_q, burst_d;
   logic first_q, first_d;
   logic rdy_hit_q, rdy_hit_d;
   logic err_hit_q, err_hit_d;
   logic start_n_q, start_n_d;
   logic bfreq_q, bfreq_d;
   logic strobe_n_q, strobe_n_d;
   logic rden_n_q, rden_n_d;
   logic wv_q, wv_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [PAR_W-1:0] wpar_q, wpar_d;
   logic wpen_q, wpen_d;
   logic wcach_q, wcach_d;
   logic wfill_q, wfill_d;
   logic done_q, done_d;
   logic exc_q, exc_d;
   logic [3:0] blk_mask;

   assign blk_mask = 4'(len_q - LEN_ONE);

   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      len_d = len_q;
      count_d = count_q;
      block_d = block_q;
      burst_d = burst_q;
      first_d = first_q;
      rdy_hit_d = rdy_hit_q;
      err_hit_d = err_hit_q;
      wv_d = 1'b0;
      wdata_d = wdata_q;
      wpar_d = wpar_q;
      wpen_d = wpen_q;
      wcach_d = wcach_q;
      wfill_d = 1'b0;
      done_d = 1'b0;
      exc_d = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (req_valid)
            begin
               state_d = ST_ADDR;
               addr_d = req_addr;
               block_d = req_block;
               len_d = req_len;
               count_d = req_len;
               burst_d = 1'b0;
               first_d = 1'b1;
            end
         end
         ST_ADDR:
            state_d = ST_STRB;
         ST_STRB:
            state_d = ST_SMPL;
         ST_SMPL:
         begin
            rdy_hit_d = rdy_s;
            err_hit_d = err_s;
            wpen_d = pen_s;
            wcach_d = cach_s;
            if (first_q && block_q && ack_s)
            begin
               burst_d = 1'b1;
               addr_d[BLK_HI:BLK_LO] = addr_q[BLK_HI:BLK_LO] & ~blk_mask;
            end
            if (rdy_s || err_s)
               state_d = ST_DATA;
            else
               state_d = ST_SMPL;
         end
         ST_DATA:
         begin
            first_d = 1'b0;
            if (err_hit_q)
            begin
               state_d = ST_IDLE;
               exc_d = 1'b1;
               done_d = 1'b1;
               addr_d = instr_addr;
            end
            else if (!burst_q)
            begin
               state_d = ST_IDLE;
               wv_d = 1'b1;
               wdata_d = data_s;
               wpar_d = par_s;
               wfill_d = wcach_q;
               done_d = 1'b1;
               addr_d = instr_addr;
            end
            else if (!rdy_hit_q)
               state_d = ST_SMPL;
            else
            begin
               wv_d = 1'b1;
               wdata_d = data_s;
               wpar_d = par_s;
               wfill_d = 1'b1;
               count_d = count_q - LEN_ONE;
               if (count_q == LEN_ONE)
               begin
                  state_d = ST_IDLE;
                  done_d = 1'b1;
                  addr_d = instr_addr;
               end
               else
               begin
                  state_d = ST_SMPL;
                  addr_d[BLK_HI:BLK_LO] = addr_q[BLK_HI:BLK_LO] + BLK_STEP;
               end
            end
         end
         default:
            state_d = ST_IDLE;
      endcase
      if (srst)
      begin
         state_d = ST_IDLE;
         addr_d = ADDR_RST;
         len_d = '0;
         count_d = '0;
         block_d = 1'b0;
         burst_d = 1'b0;
         first_d = 1'b0;
         rdy_hit_d = 1'b0;
         err_hit_d = 1'b0;
         wv_d = 1'b0;
         wdata_d = '0;
         wpar_d = '0;
         wpen_d = 1'b0;
         wcach_d = 1'b0;
         wfill_d = 1'b0;
         done_d = 1'b0;
         exc_d = 1'b0;
      end
   end

   // pin levels follow the next state so they line up with state_q
   always_comb
   begin
      start_n_d = !(state_d == ST_ADDR);
      bfreq_d = block_d && (state_d != ST_IDLE);
      strobe_n_d = (state_d == ST_IDLE) || (state_d == ST_ADDR);
      rden_n_d = strobe_n_d;
   end

   always_ff @(posedge core_clk)
   begin
      state_q <= state_d;
      addr_q <= addr_d;
      len_q <= len_d;
      count_q <= count_d;
      block_q <= block_d;
      burst_q <= burst_d;
      first_q <= first_d;
      rdy_hit_q <= rdy_hit_d;
      err_hit_q <= err_hit_d;
      start_n_q <= start_n_d;
      bfreq_q <= bfreq_d;
      strobe_n_q <= strobe_n_d;
      rden_n_q <= rden_n_d;
      wv_q <= wv_d;
      wdata_q <= wdata_d;
      wpar_q <= wpar_d;
      wpen_q <= wpen_d;
      wcach_q <= wcach_d;
      wfill_q <= wfill_d;
      done_q <= done_d;
      exc_q <= exc_d;
   end

   assign req_ready = (state_q == ST_IDLE);
   assign addr_out = addr_q;
   assign txn_start_n = start_n_q;
   assign block_fetch_request = bfreq_q;
   assign addr_strobe_n = strobe_n_q;
   assign read_enable_n = rden_n_q;
   assign word_valid = wv_q;
   assign word_data = wdata_q;
   assign word_parity = wpar_q;
   assign word_parity_check = wpen_q;
   assign word_cacheable = wcach_q;
   assign word_to_cache = wfill_q;
   assign txn_done = done_q;
   assign bus_error_exc = exc_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   start_pulse_a: assert property (
      !txn_start_n |=> txn_start_n ##0 !addr_strobe_n)
      else $error("start strobe longer than one cycle");
   strobe_on_a: assert property (
      state_q == ST_STRB |-> !addr_strobe_n && !read_enable_n)
      else $error("strobes not asserted in second state");
   wait_hold_a: assert property (
      state_q == ST_SMPL && !rdy_s && !err_s |=> state_q == ST_SMPL)
      else $error("left sampling state without ready or error");
   sample_adv_a: assert property (
      state_q == ST_SMPL && (rdy_s || err_s) |=> state_q == ST_DATA)
      else $error("did not advance on ready or error");
   word_cap_a: assert property (
      state_q == ST_DATA && !burst_q && !err_hit_q
      |=> word_valid && word_data == $past(data_s) && addr_strobe_n
         && read_enable_n && !block_fetch_request)
      else $error("word read capture or release wrong");
   addr_stall_a: assert property (
      state_q == ST_SMPL && burst_q && !rdy_s && !err_s
      |=> $stable(addr_out))
      else $error("burst address moved on a wait");
   block_req_a: assert property (
      state_q == ST_ADDR |-> block_fetch_request == block_q)
      else $error("block request level wrong in first state");
   count_load_a: assert property (
      state_q == ST_ADDR |-> count_q == len_q)
      else $error("block counter not loaded");
   error_end_a: assert property (
      state_q == ST_DATA && err_hit_q
      |=> bus_error_exc && state_q == ST_IDLE && !word_valid)
      else $error("bus error did not end transaction");
   burst_end_a: assert property (
      state_q == ST_DATA && burst_q && rdy_hit_q && !err_hit_q
      && count_q == LEN_ONE |=> addr_strobe_n && read_enable_n && txn_done)
      else $error("burst did not end at zero count");
   fill_cache_a: assert property (
      word_valid && $past(burst_q) |-> word_to_cache)
      else $error("burst word not sent to cache");
endmodule : mem_read_unit

/* core/mem_read_pkg.sv */
// constants and types for the external memory read and block fetch unit
// Behaviour
// - first state drives address on addr_out and asserts txn_start_n; block request if needed.
// - second state asserts addr_strobe_n and read_enable_n.
// - third state samples handshake inputs; advances when ready or error asserted.
// - with neither ready nor error asserted, third state repeats as wait cycle.
// - word read captures data and parity, then parks address and drops strobes.
// - block_fetch_request in first state asks for a two to sixteen word burst.
// - acknowledged burst clears address bits 5:2 modulo block size.
// - word not ready leaves burst address unchanged in fourth state.
// - burst fourth state with ready captures data and parity, increments block address unless last word.
// - third and fourth states repeat until count is zero or bus error.
// - burst end releases addr_strobe_n and read_enable_n; memory drops ready.
// - every word received by an acknowledged block fetch goes to the cache; an unacknowledged one only if cacheable_n is asserted.
// - bus error ends the transaction and raises a bus error exception.
package mem_read_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int PAR_W = 4;
   localparam int LEN_W = 5;
   localparam int BLK_LO = 2;
   localparam int BLK_HI = 5;
   localparam int SYNC_W = DATA_W + PAR_W + 5;
   localparam logic [LEN_W-1:0] LEN_ONE = 5'h01;
   localparam logic [3:0] BLK_STEP = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_STRB = 5'b00100,
      ST_SMPL = 5'b01000,
      ST_DATA = 5'b10000
   } rd_state_type;
endpackage : mem_read_pkg

/* core/pin_sync.sv */
// two flip-flop synchroniser for memory bus inputs
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = srst ? RST_VAL : pin_in;
      sync_d = srst ? RST_VAL : meta_q;
   end

   always_ff @(posedge core_clk)
   begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign pin_sync_out = sync_q;
endmodule : pin_sync

/* testbench/mem_model.sv */
// memory system model: ready and error handshake, burst acknowledge
`timescale 1ns/1ns
module mem_model (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic read_enable_n,
   input wire logic block_fetch_request,
   input wire logic [3:0] wt,
   input wire logic stall,
   input wire logic err,
   input wire logic ack,
   input wire logic cach,
   input wire logic [31:0] pat,
   output logic [31:0] data_in,
   output logic [3:0] data_parity_in,
   output logic data_ready_n,
   output logic bus_error_n,
   output logic parity_check_enable_n,
   output logic cacheable_n,
   output logic block_fetch_ack_n
);
   logic [3:0] cnt;
   logic go;
   assign go = !read_enable_n && cnt >= wt;
   assign block_fetch_ack_n = !(ack && block_fetch_request);
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cnt <= 4'h0;
         data_in <= 32'h0;
         data_parity_in <= 4'h0;
      end
      else
      begin
         cnt <= read_enable_n ? 4'h0 : go ? cnt : cnt + 4'h1;
         // released bus toggles so stale data never looks valid
         data_in <= read_enable_n ? ~data_in : pat;
         data_parity_in <= read_enable_n ? ~data_parity_in :
            {^pat[31:24], ^pat[23:16], ^pat[15:8], ^pat[7:0]};
      end
      data_ready_n <= !(go && !stall && !err);
      bus_error_n <= !(go && err);
      cacheable_n <= !(cach || block_fetch_request);
      parity_check_enable_n <= !cach;
   end
endmodule : mem_model

/* testbench/testbench.sv */
// self-checking bench for the memory read and block fetch unit
`timescale 1ns/1ns
module testbench;
   import mem_read_pkg::*;
   logic core_clk, srst, req_valid, req_block, stall, err, ack, cach;
   logic [ADDR_W-1:0] req_addr, instr_addr, addr_out;
   logic [LEN_W-1:0] req_len;
   logic [3:0] wt;
   logic [31:0] pat, lf;
   logic req_ready, txn_start_n, block_fetch_request, addr_strobe_n;
   logic read_enable_n, word_valid, word_parity_check, word_cacheable;
   logic word_to_cache, txn_done, bus_error_exc, data_ready_n;
   logic bus_error_n, parity_check_enable_n, cacheable_n;
   logic block_fetch_ack_n;
   logic [DATA_W-1:0] data_in, word_data;
   logic [PAR_W-1:0] data_parity_in, word_parity;
   int bad_count, n_checks;

   mem_read_unit u_dut (.core_clk, .srst, .req_valid, .req_block,
      .req_addr, .req_len, .instr_addr, .req_ready, .addr_out,
      .txn_start_n, .block_fetch_request, .addr_strobe_n,
      .read_enable_n, .data_in, .data_parity_in, .data_ready_n,
      .bus_error_n, .parity_check_enable_n, .cacheable_n,
      .block_fetch_ack_n, .word_valid, .word_data, .word_parity,
      .word_parity_check, .word_cacheable, .word_to_cache, .txn_done,
      .bus_error_exc);

   mem_model u_mem (.core_clk, .srst, .read_enable_n,
      .block_fetch_request, .wt, .stall, .err, .ack, .cach, .pat,
      .data_in, .data_parity_in, .data_ready_n, .bus_error_n,
      .parity_check_enable_n, .cacheable_n, .block_fetch_ack_n);

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nx

   function automatic logic [3:0] par(input logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
   endfunction : par

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] v);
      n_checks++;
      if (v !== e)
      begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", nm, e, v);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // one transaction; b block, n length, e bus error, k acknowledge
   task automatic run(input logic b, input logic [4:0] n, input logic e,
      input logic k);
      logic [31:0] a, al, pa, d;
      logic c, f;
      int w, s;
      lf = nx(lf);
      a = lf;
      lf = nx(lf);
      d = lf;
      c = lf[4];
      al = {a[31:6], a[5:2] & ~(n[3:0] - 4'h1), a[1:0]};
      pat <= d;
      instr_addr <= ~d;
      wt <= b ? 4'h1 + {2'h0, d[1:0]} : {2'h0, d[3:2]};
      cach <= c;
      err <= e;
      ack <= k;
      req_valid <= 1'b1;
      req_block <= b;
      req_addr <= a;
      req_len <= n;
      pa = a;
      f = a !== al;
      w = 0;
      s = 0;
      @(negedge core_clk);
      req_valid <= 1'b0;
      repeat (400)
      begin
         lf = nx(lf);
         stall <= lf[7] & lf[3];
         if (!txn_start_n)
         begin
            s++;
            chk("start_addr", a, addr_out);
            chk("bfreq", {31'h0, b}, {31'h0, block_fetch_request});
         end
         if (!addr_strobe_n && addr_out !== pa)
         begin
            chk("blk_addr", f ? al :
               {pa[31:6], pa[5:2] + 4'h1, pa[1:0]}, addr_out);
            f = 1'b0;
            pa = addr_out;
         end
         if (word_valid)
         begin
            w++;
            chk("data", d, word_data);
            chk("parity", {28'h0, par(d)}, {28'h0, word_parity});
            chk("to_cache", {31'h0, b | c}, {31'h0, word_to_cache});
            chk("pen", {31'h0, c}, {31'h0, word_parity_check});
            chk("cach", {31'h0, b | c}, {31'h0, word_cacheable});
         end
         if (txn_done)
            break;
         @(negedge core_clk);
      end
      chk("done", 1, {31'h0, txn_done});
      chk("starts", 1, s);
      chk("words", e ? 0 : (b && k) ? {27'h0, n} : 1, w);
      chk("exc", {31'h0, e}, {31'h0, bus_error_exc});
      chk("park", ~d, addr_out);
      chk("pins", 3'b110, {addr_strobe_n, read_enable_n,
         block_fetch_request});
      @(negedge core_clk);
      $display("test block %0d len %0d error %0d ended", b, n, e);
   endtask : run

   initial
   begin
      lf = 32'ha324b878;
      bad_count = 0;
      n_checks = 0;
      srst = 1'b1;
      req_valid = 1'b0;
      req_block = 1'b0;
      req_addr = 32'h0;
      req_len = 5'h02;
      instr_addr = 32'h0;
      wt = 4'h0;
      stall = 1'b0;
      err = 1'b0;
      ack = 1'b0;
      cach = 1'b0;
      pat = 32'h0;
      repeat (16) @(negedge core_clk);
      chk("rst_pins", 4'hf, {txn_start_n, addr_strobe_n, read_enable_n,
         req_ready});
      srst <= 1'b0;
      @(negedge core_clk);
      for (int i = 0; i < 6; i++)
         run(1'b0, 5'h01, 1'b0, 1'b0);
      for (int j = 1; j < 9; j++)
         run(1'b1, 5'h01 << (j % 4 + 1), 1'b0, 1'b1);
      run(1'b1, 5'h04, 1'b0, 1'b0);
      run(1'b0, 5'h01, 1'b1, 1'b0);
      run(1'b1, 5'h08, 1'b1, 1'b1);
      run(1'b0, 5'h01, 1'b0, 1'b0);
      give_verdict;
   end

   initial
   begin
      #80000;
      bad_count++;
      $display("watchdog expired");
      give_verdict;
   end
endmodule : testbench
